// ---- pscr_config_regs.v ----
// Protection and share configuration register bank with power-up shadow load
`timescale 1ns/100ps
`include "pscr_regs.vh"
`default_nettype none

module pscr_config_regs #(
    parameter integer OV_REC_STEP_CYCLES = (`PSCR_CLK_HZ / 1000000) * `PSCR_OV_REC_STEP_US
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port from the serial engine
    input wire [7:0] reg_addr,
    input wire reg_wr_stb,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Shadow memory read port
    output reg nvm_rd_req,
    output reg [15:0] nvm_rd_addr,
    input wire nvm_rd_valid,
    input wire [7:0] nvm_rd_data,
    output reg cfg_loaded,
    // Shadow memory write check
    input wire [15:0] nvm_wr_addr,
    output wire nvm_wr_blocked,
    // Power sequencing
    input wire mains_good,
    input wire power_enable_request,
    input wire softstart_request,
    output reg power_enable_output,
    output reg softstart_enable,
    // Overvoltage recovery timing
    input wire ov_recover_start,
    output reg ov_recover_done,
    // Analog trims and region lock outputs
    output reg [8:0] rev_off_threshold_mv,
    output reg [5:0] rev_on_threshold_mv,
    output reg [4:0] current_limit_trim,
    output reg [8:0] share_ok_window_mv,
    output reg [7:0] share_offset_trim,
    output reg [6:0] share_slope_trim,
    output wire [6:0] nvm_region_protect
);

    // ----------------------------------------------------------------
    // Registers and loader state
    // ----------------------------------------------------------------
    // Loader runs REQ then WAIT once per shadow byte, then parks in DONE
    // DONE is left only by reset, so stray valids cannot reload the bank
    localparam [1:0] LD_REQ = 2'h0;
    localparam [1:0] LD_WAIT = 2'h1;
    localparam [1:0] LD_DONE = 2'h2;

    // Shadow-backed configuration registers
    reg [7:0] calibration_bits_q;
    reg [7:0] current_sense_limit_cfg_q;
    reg [7:0] current_share_offset_q;
    reg [7:0] current_share_slope_q;
    reg [7:0] nvm_region_locks_q;
    reg [1:0] ld_state_q;
    reg [2:0] ld_idx_q;
    // Mains-good synchroniser pair
    reg mains_meta_q;
    reg mains_good_q;
    // Recovery delay; 16 bits hold four steps at the default clock
    reg [15:0] ovr_cnt_q;
    reg ovr_busy_q;

    // Loader and write decode
    wire [7:0] ld_ofs;
    wire ld_take;
    wire [7:0] wr_ofs;
    wire wr_ok;
    wire [15:0] ovr_target;

    // Offset currently being filled by the loader
    assign ld_ofs = `PSCR_OFS_CALIBRATION_BITS + {5'h00, ld_idx_q};
    assign ld_take = (ld_state_q == LD_WAIT) && nvm_rd_valid;
    // Software writes are dropped until the load is done so a late shadow byte cannot overwrite them
    assign wr_ok = reg_wr_stb && (ld_state_q == LD_DONE);
    assign wr_ofs = reg_addr;

    // ----------------------------------------------------------------
    // Power-up shadow loader
    // ----------------------------------------------------------------
    // Request and address stand until valid, then the request drops
    // for one cycle before the next address goes out.
    // No timeout: a memory that never answers leaves the bank unloaded.
    always @(posedge clk) begin
        if (!reset_n) begin
            // Start again from the first shadow byte
            ld_state_q <= LD_REQ;
            ld_idx_q <= 3'h0;
            nvm_rd_req <= 1'b0;
            nvm_rd_addr <= `PSCR_SHADOW_BASE;
            cfg_loaded <= 1'b0;
        end else begin
            case (ld_state_q)
                LD_REQ: begin
                    nvm_rd_req <= 1'b1;
                    nvm_rd_addr <= `PSCR_SHADOW_BASE + {13'h0000, ld_idx_q};
                    ld_state_q <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (nvm_rd_valid) begin
                        nvm_rd_req <= 1'b0;
                        if (ld_idx_q == `PSCR_NUM_REGS - 3'h1) begin
                            ld_state_q <= LD_DONE;
                            cfg_loaded <= 1'b1;
                        end else begin
                            ld_idx_q <= ld_idx_q + 3'h1;
                            ld_state_q <= LD_REQ;
                        end
                    end
                end
                LD_DONE: begin
                    // Parked: software owns the bank from here
                    nvm_rd_req <= 1'b0;
                end
                default: begin
                    ld_state_q <= LD_REQ;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register storage: shadow load first, software writes after
    // ----------------------------------------------------------------
    // Loader and software never collide: writes before DONE are dropped
    // Unmapped offsets fall to the default arm and change nothing
    always @(posedge clk) begin
        if (!reset_n) begin
            calibration_bits_q <= `PSCR_RST_CALIBRATION_BITS;
            current_sense_limit_cfg_q <= `PSCR_RST_CURRENT_SENSE_LIMIT_CFG;
            current_share_offset_q <= `PSCR_RST_CURRENT_SHARE_OFFSET;
            current_share_slope_q <= `PSCR_RST_CURRENT_SHARE_SLOPE;
            nvm_region_locks_q <= `PSCR_RST_NVM_REGION_LOCKS;
        end else if (ld_take) begin
            case (ld_ofs)
                `PSCR_OFS_CALIBRATION_BITS: calibration_bits_q <= nvm_rd_data;
                `PSCR_OFS_CURRENT_SENSE_LIMIT_CFG: current_sense_limit_cfg_q <= nvm_rd_data;
                `PSCR_OFS_CURRENT_SHARE_OFFSET: current_share_offset_q <= nvm_rd_data;
                `PSCR_OFS_CURRENT_SHARE_SLOPE: current_share_slope_q <= nvm_rd_data;
                `PSCR_OFS_NVM_REGION_LOCKS: nvm_region_locks_q <= nvm_rd_data;
                default: nvm_region_locks_q <= nvm_region_locks_q;
            endcase
        end else if (wr_ok) begin
            // All bits store as written, reserved ones too, so reads echo software
            case (wr_ofs)
                `PSCR_OFS_CALIBRATION_BITS: calibration_bits_q <= reg_wdata;
                `PSCR_OFS_CURRENT_SENSE_LIMIT_CFG: current_sense_limit_cfg_q <= reg_wdata;
                `PSCR_OFS_CURRENT_SHARE_OFFSET: current_share_offset_q <= reg_wdata;
                `PSCR_OFS_CURRENT_SHARE_SLOPE: current_share_slope_q <= reg_wdata;
                `PSCR_OFS_NVM_REGION_LOCKS: nvm_region_locks_q <= reg_wdata;
                default: nvm_region_locks_q <= nvm_region_locks_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read data, registered one cycle after the address
    // ----------------------------------------------------------------
    // Unmapped offsets read zero; reads have no side effects
    // During the load a read shows what has arrived so far
    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= `PSCR_READ_UNMAPPED;
        end else begin
            case (reg_addr)
                `PSCR_OFS_CALIBRATION_BITS: reg_rdata <= calibration_bits_q;
                `PSCR_OFS_CURRENT_SENSE_LIMIT_CFG: reg_rdata <= current_sense_limit_cfg_q;
                `PSCR_OFS_CURRENT_SHARE_OFFSET: reg_rdata <= current_share_offset_q;
                `PSCR_OFS_CURRENT_SHARE_SLOPE: reg_rdata <= current_share_slope_q;
                `PSCR_OFS_NVM_REGION_LOCKS: reg_rdata <= nvm_region_locks_q;
                default: reg_rdata <= `PSCR_READ_UNMAPPED;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Mains-good synchroniser and gated enables
    // ----------------------------------------------------------------
    // Only the second flop feeds the gates, so a metastable first
    // flop never reaches the enables; requests share our clock.
    // Gating costs three cycles of latency on mains-good, two of them in the synchroniser
    always @(posedge clk) begin
        if (!reset_n) begin
            mains_meta_q <= 1'b0;
            mains_good_q <= 1'b0;
            power_enable_output <= 1'b0;
            softstart_enable <= 1'b0;
        end else begin
            mains_meta_q <= mains_good;
            mains_good_q <= mains_meta_q;
            // Nothing is enabled before the configuration is known
            power_enable_output <= cfg_loaded && power_enable_request &&
                (!calibration_bits_q[`PSCR_POWER_ENABLE_GATE_OPTION_BIT] || mains_good_q);
            softstart_enable <= cfg_loaded && softstart_request &&
                (!calibration_bits_q[`PSCR_RAMP_GATE_BIT] || mains_good_q);
        end
    end

    // ----------------------------------------------------------------
    // Overvoltage recovery delay: (code + 1) steps of 100 us
    // ----------------------------------------------------------------
    // Code is read live, so a rewrite mid-wait moves the end point
    // Target is the step length times (code + 1)
    assign ovr_target = OV_REC_STEP_CYCLES[15:0] *
        ({14'h0000, calibration_bits_q[`PSCR_OV_REC_HI:`PSCR_OV_REC_LO]} + 16'h0001);

    // Done is a one-cycle pulse; a fresh start restarts the count
    always @(posedge clk) begin
        if (!reset_n) begin
            ovr_cnt_q <= 16'h0000;
            ovr_busy_q <= 1'b0;
            ov_recover_done <= 1'b0;
        end else begin
            ov_recover_done <= 1'b0;
            if (ov_recover_start) begin
                // A fresh start restarts the wait with the count reloaded to one
                ovr_busy_q <= 1'b1;
                ovr_cnt_q <= 16'h0001;
            end else if (ovr_busy_q) begin
                if (ovr_cnt_q >= ovr_target) begin
                    ovr_busy_q <= 1'b0;
                    ov_recover_done <= 1'b1;
                end else begin
                    ovr_cnt_q <= ovr_cnt_q + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Decoded trims for the analog side
    // ----------------------------------------------------------------
    // Registered so the analog side sees clean levels; each trim
    // follows its register one cycle late
    always @(posedge clk) begin
        if (!reset_n) begin
            rev_off_threshold_mv <= `PSCR_REV_OFF_BASE_MV;
            rev_on_threshold_mv <= `PSCR_REV_ON_BASE_MV;
            current_limit_trim <= 5'h00;
            share_ok_window_mv <= `PSCR_SHARE_OK_STEP_MV;
            share_offset_trim <= 8'h00;
            share_slope_trim <= 7'h00;
        end else begin
            rev_off_threshold_mv <= `PSCR_REV_OFF_BASE_MV + `PSCR_REV_OFF_STEP_MV *
                {7'h00, calibration_bits_q[`PSCR_REV_OFF_HI:`PSCR_REV_OFF_LO]};
            rev_on_threshold_mv <= `PSCR_REV_ON_BASE_MV + `PSCR_REV_ON_STEP_MV *
                {4'h0, calibration_bits_q[`PSCR_REV_ON_HI:`PSCR_REV_ON_LO]};
            // All ones is the 130% ceiling; the analog ladder sets the scale
            current_limit_trim <= current_sense_limit_cfg_q[`PSCR_ILIM_HI:`PSCR_ILIM_LO];
            // Bit 2 is left out on purpose; software keeps it at zero
            share_ok_window_mv <= `PSCR_SHARE_OK_STEP_MV *
                ({7'h00, current_sense_limit_cfg_q[`PSCR_SHARE_OK_HI:`PSCR_SHARE_OK_LO]} + 9'h001);
            share_offset_trim <= current_share_offset_q;
            share_slope_trim <= current_share_slope_q[`PSCR_SLOPE_HI:`PSCR_SLOPE_LO];
        end
    end

    // ----------------------------------------------------------------
    // Shadow memory write protection, one comparator pair per lock bit
    // ----------------------------------------------------------------
    // Checked against the proposed write address with no clock, so the
    // memory controller can refuse the write in the same cycle.
    // One 16-bit first and last pair per lock, lock 0 lowest
    localparam [16*`PSCR_NUM_LOCKS-1:0] LOCK_FIRST = `PSCR_LOCK_FIRST;
    localparam [16*`PSCR_NUM_LOCKS-1:0] LOCK_LAST = `PSCR_LOCK_LAST;
    wire [`PSCR_NUM_LOCKS-1:0] lock_hit;

    genvar gi;
    generate
        for (gi = 0; gi < `PSCR_NUM_LOCKS; gi = gi + 1) begin : g_lock
            assign lock_hit[gi] = nvm_region_locks_q[gi] &&
                (nvm_wr_addr >= LOCK_FIRST[16*gi +: 16]) &&
                (nvm_wr_addr <= LOCK_LAST[16*gi +: 16]);
        end
    endgenerate

    // Bit 7 takes part in nothing
    // Region 5 holds the calibration set and is normally left locked
    assign nvm_region_protect = nvm_region_locks_q[`PSCR_NUM_LOCKS-1:0];
    assign nvm_wr_blocked = |lock_hit;

endmodule // pscr_config_regs

`default_nettype wire

// ---- pscr_config_regs_checker.sv ----
// Assertion checker for the protection and share configuration bank
`timescale 1ns/100ps
`default_nettype none

module pscr_config_regs_checker #(
    parameter integer OV_REC_STEP_CYCLES = 2000
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register and shadow ports
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire nvm_rd_req,
    input wire [15:0] nvm_rd_addr,
    input wire nvm_rd_valid,
    input wire cfg_loaded,
    input wire [15:0] nvm_wr_addr,
    input wire nvm_wr_blocked,
    input wire [6:0] nvm_region_protect,
    // Sequencing and trims
    input wire power_enable_request,
    input wire softstart_request,
    input wire power_enable_output,
    input wire softstart_enable,
    input wire ov_recover_start,
    input wire ov_recover_done,
    input wire [8:0] rev_off_threshold_mv,
    input wire [5:0] rev_on_threshold_mv,
    input wire [8:0] share_ok_window_mv
);
    // ------------------------------------------------------------
    // One clock domain, so one default clocking and disable
    // ------------------------------------------------------------
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_load_addr_range: assert property (nvm_rd_req |-> nvm_rd_addr >= 16'h8103 && nvm_rd_addr <= 16'h8107)
        else $error("shadow read address out of range");
    a_load_req_holds: assert property (nvm_rd_req && !nvm_rd_valid |=> nvm_rd_req && $stable(nvm_rd_addr))
        else $error("shadow request dropped or moved before answer");
    a_load_next_addr: assert property (nvm_rd_req && nvm_rd_valid && nvm_rd_addr != 16'h8107
        |=> ##1 nvm_rd_req && nvm_rd_addr == $past(nvm_rd_addr, 2) + 16'h0001)
        else $error("next shadow address not one above the last");
    a_load_done_flag: assert property (nvm_rd_req && nvm_rd_valid && nvm_rd_addr == 16'h8107 |-> ##[1:3] cfg_loaded)
        else $error("load complete flag missing after last byte");
    a_pen_needs_req: assert property (!power_enable_request |=> !power_enable_output)
        else $error("power enable high without request");
    a_ramp_needs_req: assert property (!softstart_request |=> !softstart_enable)
        else $error("soft start enabled without request");
    a_rev_off_codes: assert property (rev_off_threshold_mv inside {9'd100, 9'd150, 9'd200, 9'd250})
        else $error("reverse off threshold not a legal step");
    a_rev_on_codes: assert property (rev_on_threshold_mv inside {6'd20, 6'd30, 6'd40, 6'd50})
        else $error("reverse on threshold not a legal step");
    a_window_codes: assert property (share_ok_window_mv inside {9'd100, 9'd200, 9'd300, 9'd400})
        else $error("share window not a legal step");
    a_ov_not_early: assert property (ov_recover_start |=> !ov_recover_done [*3])
        else $error("recovery done too soon after start");
    a_lock_low_region: assert property (nvm_region_protect[0] && nvm_wr_addr <= 16'h803f
        && nvm_wr_addr >= 16'h8000 |-> nvm_wr_blocked)
        else $error("write to locked low region not blocked");
    a_lock_cal_region: assert property (nvm_region_protect[5] && nvm_wr_addr >= 16'h8120
        && nvm_wr_addr <= 16'h813f |-> nvm_wr_blocked)
        else $error("write to locked calibration region not blocked");
    a_unlocked_free: assert property (nvm_region_protect == 7'h00 |-> !nvm_wr_blocked)
        else $error("write blocked with no lock set");
    a_locks_readback: assert property (reg_addr == 8'h07 |=> reg_rdata[6:0] == $past(nvm_region_protect))
        else $error("lock register read back differs from lock outputs");
endmodule // pscr_config_regs_checker

bind pscr_config_regs pscr_config_regs_checker #(.OV_REC_STEP_CYCLES(OV_REC_STEP_CYCLES)) u_chk (.clk(clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .nvm_rd_req(nvm_rd_req),
    .nvm_rd_addr(nvm_rd_addr), .nvm_rd_valid(nvm_rd_valid), .cfg_loaded(cfg_loaded), .nvm_wr_addr(nvm_wr_addr),
    .nvm_wr_blocked(nvm_wr_blocked), .nvm_region_protect(nvm_region_protect),
    .power_enable_request(power_enable_request), .softstart_request(softstart_request),
    .power_enable_output(power_enable_output), .softstart_enable(softstart_enable),
    .ov_recover_start(ov_recover_start), .ov_recover_done(ov_recover_done),
    .rev_off_threshold_mv(rev_off_threshold_mv), .rev_on_threshold_mv(rev_on_threshold_mv),
    .share_ok_window_mv(share_ok_window_mv));
`default_nettype wire

// ---- pscr_end_marker.v ----
// Restores the default net type after the design sources
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- pscr_regs.vh ----
// Register offsets, fields, reset values and timing for the protection and share configuration bank
`ifndef PSCR_REGS_VH
`define PSCR_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSCR_OFS_CALIBRATION_BITS 8'h03
`define PSCR_OFS_CURRENT_SENSE_LIMIT_CFG 8'h04
`define PSCR_OFS_CURRENT_SHARE_OFFSET 8'h05
`define PSCR_OFS_CURRENT_SHARE_SLOPE 8'h06
`define PSCR_OFS_NVM_REGION_LOCKS 8'h07
`define PSCR_NUM_REGS 3'h5

// ----------------------------------------------------------------
// Shadow locations and reset values
// ----------------------------------------------------------------
`define PSCR_SHADOW_BASE 16'h8103
`define PSCR_RST_CALIBRATION_BITS 8'h00
`define PSCR_RST_CURRENT_SENSE_LIMIT_CFG 8'h00
`define PSCR_RST_CURRENT_SHARE_OFFSET 8'h00
`define PSCR_RST_CURRENT_SHARE_SLOPE 8'hfe
`define PSCR_RST_NVM_REGION_LOCKS 8'h20
`define PSCR_READ_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSCR_REV_OFF_HI 7
`define PSCR_REV_OFF_LO 6
`define PSCR_REV_ON_HI 5
`define PSCR_REV_ON_LO 4
`define PSCR_POWER_ENABLE_GATE_OPTION_BIT 3
`define PSCR_RAMP_GATE_BIT 2
`define PSCR_OV_REC_HI 1
`define PSCR_OV_REC_LO 0
`define PSCR_ILIM_HI 7
`define PSCR_ILIM_LO 3
`define PSCR_SHARE_OK_HI 1
`define PSCR_SHARE_OK_LO 0
`define PSCR_SLOPE_HI 7
`define PSCR_SLOPE_LO 1
`define PSCR_NUM_LOCKS 7

// ----------------------------------------------------------------
// Threshold and window encodings, in millivolts
// ----------------------------------------------------------------
`define PSCR_REV_OFF_BASE_MV 9'h064
`define PSCR_REV_OFF_STEP_MV 9'h032
`define PSCR_REV_ON_BASE_MV 6'h14
`define PSCR_REV_ON_STEP_MV 6'h0a
`define PSCR_SHARE_OK_STEP_MV 9'h064

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSCR_CLK_HZ 20000000
`define PSCR_OV_REC_STEP_US 100

// ----------------------------------------------------------------
// Lock regions: first and last byte address of each
// ----------------------------------------------------------------
`define PSCR_LOCK_FIRST {16'h8140, 16'h8120, 16'h8100, 16'h80c0, 16'h8080, 16'h8040, 16'h8000}
`define PSCR_LOCK_LAST {16'h817f, 16'h813f, 16'h811f, 16'h80ff, 16'h80bf, 16'h807f, 16'h803f}

`endif

// ---- test_pscr_config_regs.sv ----
// Self-checking bench for the protection and share configuration bank
`timescale 1ns/100ps
`default_nettype none

module test_pscr_config_regs;
    // ------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ------------------------------------------------------------
    localparam int STEP = 4; // Short recovery step keeps the run brief
    typedef struct {int sel; logic [15:0] exp;} pscr_note_t;
    logic clk = 1'b0, reset_n = 1'b0, reg_wr_stb = 1'b0, nvm_rd_valid = 1'b0, mains_good = 1'b0;
    logic power_enable_request = 1'b0, softstart_request = 1'b0, ov_recover_start = 1'b0, ov_ok = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, nvm_rd_data = 8'h00, r, s, share_offset_trim, reg_rdata;
    logic [15:0] nvm_wr_addr = 16'h0000, nvm_rd_addr;
    logic nvm_rd_req, cfg_loaded, nvm_wr_blocked, power_enable_output, softstart_enable, ov_recover_done;
    logic [8:0] rev_off_threshold_mv, share_ok_window_mv;
    logic [5:0] rev_on_threshold_mv;
    logic [4:0] current_limit_trim;
    logic [6:0] share_slope_trim, nvm_region_protect;
    logic [7:0] ld [5];
    logic [1:0] b;
    logic [15:0] first_a [7] = '{16'h8000, 16'h8040, 16'h8080, 16'h80c0, 16'h8100, 16'h8120, 16'h8140};
    logic [15:0] last_a [7] = '{16'h803f, 16'h807f, 16'h80bf, 16'h80ff, 16'h811f, 16'h813f, 16'h817f};
    string names [16] = '{"reg_rdata", "nvm_rd_addr", "nvm_wr_blocked", "power_enable_output",
        "softstart_enable", "rev_off", "rev_on", "limit_trim", "window", "offset", "slope", "protect",
        "ov_delay_ok", "cfg_loaded", "nvm_rd_req", "ov_recover_done"};
    pscr_note_t notes [$];
    pscr_note_t cur;
    int mismatches = 0, samples_checked = 0, n;

    always #25 clk = ~clk;

    pscr_config_regs #(.OV_REC_STEP_CYCLES(STEP)) uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nvm_rd_req(nvm_rd_req),
        .nvm_rd_addr(nvm_rd_addr), .nvm_rd_valid(nvm_rd_valid), .nvm_rd_data(nvm_rd_data),
        .cfg_loaded(cfg_loaded), .nvm_wr_addr(nvm_wr_addr), .nvm_wr_blocked(nvm_wr_blocked),
        .mains_good(mains_good), .power_enable_request(power_enable_request),
        .softstart_request(softstart_request), .power_enable_output(power_enable_output),
        .softstart_enable(softstart_enable), .ov_recover_start(ov_recover_start),
        .ov_recover_done(ov_recover_done), .rev_off_threshold_mv(rev_off_threshold_mv),
        .rev_on_threshold_mv(rev_on_threshold_mv), .current_limit_trim(current_limit_trim),
        .share_ok_window_mv(share_ok_window_mv), .share_offset_trim(share_offset_trim),
        .share_slope_trim(share_slope_trim), .nvm_region_protect(nvm_region_protect));

    // Output picked by a note's selector
    function automatic logic [15:0] seen_of(input int k);
        case (k)
            0: return reg_rdata; 1: return nvm_rd_addr; 2: return nvm_wr_blocked; 3: return power_enable_output;
            4: return softstart_enable; 5: return rev_off_threshold_mv; 6: return rev_on_threshold_mv;
            7: return current_limit_trim; 8: return share_ok_window_mv; 9: return share_offset_trim;
            10: return share_slope_trim; 11: return nvm_region_protect; 12: return ov_ok;
            13: return cfg_loaded; 14: return nvm_rd_req; default: return ov_recover_done;
        endcase
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            mismatches++;
        end
    endtask

    task automatic tally_and_finish();
        $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic note(input int k, input logic [15:0] e);
        notes.push_back('{k, e});
    endtask

    // One byte write, strobe for a single cycle, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_stb = 1'b1;
        @(negedge clk);
        reg_wr_stb = 1'b0;
        @(negedge clk);
    endtask

    // Bounded wait for a flag; counts the cycles spent
    task automatic wait_hi(input int k, output int c);
        c = 0;
        while (seen_of(k) !== 16'h0001) begin
            c++;
            if (c > 60) begin
                $display("Timeout waiting on %s", names[k]);
                mismatches++;
                tally_and_finish();
            end
            @(negedge clk);
        end
    endtask

    task automatic probe(input logic [15:0] a, input logic e);
        nvm_wr_addr = a;
        note(2, e);
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Watcher: settled outputs compared 5 ns after inputs move
    // ------------------------------------------------------------
    always begin
        @(negedge clk);
        #5;
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            check(names[cur.sel], seen_of(cur.sel), cur.exp);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(15158));
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        // Shadow loader: a write to 03h mid-load must be dropped
        for (int i = 0; i < 5; i++) begin
            wait_hi(14, n);
            note(1, 16'h8103 + i);
            if (i == 2)
                wr(8'h03, ~ld[0]);
            ld[i] = $urandom;
            nvm_rd_valid = 1'b1;
            nvm_rd_data = ld[i];
            @(negedge clk);
            nvm_rd_valid = 1'b0;
            nvm_rd_data = ~ld[i]; // Released bus shows the inverse, not the last byte
        end
        wait_hi(13, n);
        for (int i = 0; i < 5; i++) begin
            reg_addr = 8'h03 + i;
            @(negedge clk);
            note(0, ld[i]);
        end
        // Every code of the two-bit fields, trims and recovery delay
        for (int k = 0; k < 4; k++) begin
            b = k;
            r = $urandom;
            s = ~r;
            if (k == 3)
                r[7:3] = 5'h1f;
            wr(8'h03, {b, b, 2'b00, b});
            wr(8'h04, {r[7:3], 1'b0, b});
            wr(8'h05, r);
            wr(8'h06, s);
            note(5, 100 + 50 * k);
            note(6, 20 + 10 * k);
            note(7, r[7:3]);
            note(8, 100 * (k + 1));
            note(9, r);
            note(10, s[7:1]);
            note(0, s);
            ov_recover_start = 1'b1;
            @(negedge clk);
            ov_recover_start = 1'b0;
            wait_hi(15, n);
            ov_ok = (n + 1 >= STEP * (k + 1)) && (n + 1 <= STEP * (k + 1) + 2);
            note(12, 1'b1);
            @(negedge clk);
        end
        // Gating of both enables by mains-good, with requests crossed
        for (int j = 0; j < 8; j++) begin
            wr(8'h03, {4'h0, j[0], j[0], 2'b00});
            mains_good = j[1];
            power_enable_request = j[2];
            softstart_request = !j[2];
            repeat (4) @(negedge clk);
            note(3, j[2] & (!j[0] | j[1]));
            note(4, !j[2] & (!j[0] | j[1]));
        end
        // Each lock bit alone, bit 7 set as well to show it is unused
        for (int i = 0; i < 7; i++) begin
            wr(8'h07, 8'h80 | (8'h01 << i));
            note(11, 16'h0001 << i);
            probe(first_a[i], 1'b1);
            probe(last_a[i], 1'b1);
            probe(last_a[i] + 16'h0001, 1'b0);
            probe(first_a[i] - 16'h0001, 1'b0);
        end
        // Unmapped offset reads zero and leaves the bank alone
        wr(8'h08, 8'hff);
        note(0, 8'h00);
        reg_addr = 8'h07;
        @(negedge clk);
        note(0, 8'hc0);
        // Only the unused bit set: nothing may be blocked
        wr(8'h07, 8'h80);
        note(11, 16'h0000);
        probe(16'h8120, 1'b0);
        @(negedge clk);
        #10;
        tally_and_finish();
    end
endmodule // test_pscr_config_regs
`default_nettype wire
